// ### rfpg_chk_assertions.sv
// checker for the rail mask register bank
`timescale 1ns/1ps
`default_nettype none
module rfpg_chk (
  input wire logic clk_sys, rst, reg_rd, reg_rvalid, shutdown_req,
  input wire logic general_output_one,
  input wire logic [7:0] reg_addr, reg_rdata, rail_fault_a, rail_fault_b,
  input wire logic [7:0] rail_pg_a, rail_fault_mask_a_out,
  input wire logic [7:0] rail_fault_mask_b_out, output_one_pg_select_a_out);
  logic [2:0] n_reg;
  wire ok = &n_reg;
  always @(posedge clk_sys)
    n_reg <= rst ? 3'h0 : n_reg + {2'h0, !ok};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_fault_a: assert property (ok && |($past(rail_fault_a, 3) &
    ~rail_fault_mask_a_out) |-> shutdown_req) else $error("fault a");
  a_fault_b: assert property (ok && |($past(rail_fault_b, 3) &
    ~rail_fault_mask_b_out & 8'h1f) |-> shutdown_req) else $error("fault b");
  a_fault_none: assert property (ok && $past(rail_fault_a, 3) == 0 &&
    $past(rail_fault_b, 3) == 0 |-> !shutdown_req) else $error("fault");
  a_pg_tree: assert property (ok |-> general_output_one ==
    &($past(rail_pg_a, 3) | output_one_pg_select_a_out)) else $error("pg");
  a_pg_all_out: assert property (ok && &output_one_pg_select_a_out |->
    general_output_one) else $error("pg mask");
  a_mask_ro: assert property (ok |-> !rail_fault_mask_b_out[7])
    else $error("ro mask");
  a_read_ro: assert property (ok && reg_rd && reg_addr == 8'ha3 |=>
    !reg_rdata[7]) else $error("ro read");
  a_read_strobe: assert property (ok |-> reg_rvalid == $past(reg_rd))
    else $error("rvalid");
endmodule
`default_nettype wire

// ### rfpg_defs.vh
// constants for the rail fault mask and power-good select register bank
// Function
// - override clear: pins or internal pg control ldo
// - override set: ldo follows the disable control, on only while it is high
// - mask a: ldo two, switch a, step-downs
// - mask zero lets fault shut device down (all of mask a, bits 4 to 0 of mask b)
// - mask b: ldo one, termination, switches, ldo three
// - select zero includes rail in output tree
// - select a: ldo two, switch a, step-downs
// - reset contents come from factory configuration
`ifndef RFPG_DEFS_VH
`define RFPG_DEFS_VH
`define RFPG_ADDR_OVERRIDE_B 8'hA1
`define RFPG_ADDR_FAULT_MASK_A 8'hA2
`define RFPG_ADDR_FAULT_MASK_B 8'hA3
`define RFPG_ADDR_PG_SELECT_A 8'hA4
`define RFPG_BIT_THIRD_LDO_FORCE_ON 0
`define RFPG_BIT_MASK_B_RO 7
`define RFPG_MASK_B_RO_VALUE 1'b0
`define RFPG_MASK_B_WR_BITS 8'h7F
`define RFPG_RAIL_MASK_A_SECOND_LDO 7
`define RFPG_RAIL_MASK_A_SWITCH_A 6
`define RFPG_RAIL_MASK_B_FIRST_LDO 4
`define RFPG_RAIL_MASK_B_TERMINATION 3
`define RFPG_RAIL_MASK_B_SWITCH_B_TWO 2
`define RFPG_RAIL_MASK_B_SWITCH_B_ONE 1
`define RFPG_RAIL_MASK_B_THIRD_LDO 0
`endif

// ### rfpg_host.sv
// host register access model
`timescale 1ns/1ps
`default_nettype none
module rfpg_host (
  input wire logic clk_sys,
  output logic reg_wr, reg_rd,
  output logic [7:0] reg_addr, reg_wdata);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  task automatic acc(input logic w, input logic [7:0] a, d);
  begin
    @(negedge clk_sys);
    {reg_wr, reg_rd, reg_addr} = {w, !w, a};
    reg_wdata = a == 8'ha3 ? {d[7], 2'b01, d[4:0]} : d;
    @(negedge clk_sys);
    {reg_wr, reg_rd} = 2'h0;
  end
  endtask
endmodule
`default_nettype wire

// ### rfpg_regs.v
// rail fault mask, power-good select and third ldo override registers
`timescale 1ns/1ps
`default_nettype none
`include "rfpg_defs.vh"
module rfpg_regs
(
  input wire clk_sys,
  input wire rst,
  input wire [7:0] otp_override_b,
  input wire [7:0] otp_fault_mask_a,
  input wire [7:0] otp_fault_mask_b,
  input wire [7:0] otp_pg_select_a,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire [7:0] rail_fault_a,
  input wire [7:0] rail_fault_b,
  input wire [7:0] rail_pg_a,
  input wire third_ldo_ctl_pin_en,
  input wire third_ldo_internal_pg_en,
  input wire third_ldo_disable_ctl,
  output reg shutdown_req,
  output reg general_output_one,
  output reg third_ldo_enable,
  output reg [7:0] rail_fault_mask_a_out,
  output reg [7:0] rail_fault_mask_b_out,
  output reg [7:0] output_one_pg_select_a_out
);
  reg [7:0] fault_a_s1_reg;
  reg [7:0] fault_a_s2_reg;
  reg [7:0] fault_b_s1_reg;
  reg [7:0] fault_b_s2_reg;
  reg [7:0] pg_a_s1_reg;
  reg [7:0] pg_a_s2_reg;
  reg [2:0] ctl_s1_reg;
  reg [2:0] ctl_s2_reg;
  reg [7:0] rail_enable_override_b_reg;
  reg [7:0] rail_fault_mask_a_reg;
  reg [6:0] rail_fault_mask_b_reg;
  reg [7:0] output_one_pg_select_a_reg;
  reg load_pending_reg;
  reg [7:0] rdata_next;
  wire [7:0] mask_b_full;
  wire force_on;

  // bit seven has no storage and always reads its fixed value
  assign mask_b_full = {`RFPG_MASK_B_RO_VALUE, rail_fault_mask_b_reg};
  assign force_on = rail_enable_override_b_reg[`RFPG_BIT_THIRD_LDO_FORCE_ON];

  // pin-side inputs pass two flops
  always @(posedge clk_sys)
  begin
    fault_a_s1_reg <= rail_fault_a;
    fault_a_s2_reg <= fault_a_s1_reg;
    fault_b_s1_reg <= rail_fault_b;
    fault_b_s2_reg <= fault_b_s1_reg;
    pg_a_s1_reg <= rail_pg_a;
    pg_a_s2_reg <= pg_a_s1_reg;
    ctl_s1_reg <= {third_ldo_ctl_pin_en, third_ldo_internal_pg_en,
                   third_ldo_disable_ctl};
    ctl_s2_reg <= ctl_s1_reg;
  end

  // register storage; factory values captured on the cycle after reset
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      load_pending_reg <= 1'b1;
      rail_enable_override_b_reg <= 8'h00;
      rail_fault_mask_a_reg <= 8'hFF;
      rail_fault_mask_b_reg <= 7'h7F;
      output_one_pg_select_a_reg <= 8'hFF;
    end
    else if (load_pending_reg)
    begin
      load_pending_reg <= 1'b0;
      rail_enable_override_b_reg <= otp_override_b;
      rail_fault_mask_a_reg <= otp_fault_mask_a;
      rail_fault_mask_b_reg <= otp_fault_mask_b[6:0];
      output_one_pg_select_a_reg <= otp_pg_select_a;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `RFPG_ADDR_OVERRIDE_B:
          rail_enable_override_b_reg <= reg_wdata;
        `RFPG_ADDR_FAULT_MASK_A:
          rail_fault_mask_a_reg <= reg_wdata;
        `RFPG_ADDR_FAULT_MASK_B:
          rail_fault_mask_b_reg <= reg_wdata[6:0];
        `RFPG_ADDR_PG_SELECT_A:
          output_one_pg_select_a_reg <= reg_wdata;
        default:
          rail_fault_mask_a_reg <= rail_fault_mask_a_reg;
      endcase
    end
  end

  always @*
  begin
    case (reg_addr)
      `RFPG_ADDR_OVERRIDE_B: rdata_next = rail_enable_override_b_reg;
      `RFPG_ADDR_FAULT_MASK_A: rdata_next = rail_fault_mask_a_reg;
      `RFPG_ADDR_FAULT_MASK_B: rdata_next = mask_b_full;
      `RFPG_ADDR_PG_SELECT_A: rdata_next = output_one_pg_select_a_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data, outputs and rail logic
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      shutdown_req <= 1'b0;
      general_output_one <= 1'b0;
      third_ldo_enable <= 1'b0;
      rail_fault_mask_a_out <= 8'h00;
      rail_fault_mask_b_out <= 8'h00;
      output_one_pg_select_a_out <= 8'h00;
    end
    else
    begin
      reg_rvalid <= reg_rd & ~load_pending_reg;
      reg_rdata <= (reg_rd & ~load_pending_reg) ? rdata_next : reg_rdata;
      rail_fault_mask_a_out <= rail_fault_mask_a_reg;
      rail_fault_mask_b_out <= mask_b_full;
      output_one_pg_select_a_out <= output_one_pg_select_a_reg;
      shutdown_req <= ~load_pending_reg &
        ((|(fault_a_s2_reg & ~rail_fault_mask_a_reg)) |
         (|(fault_b_s2_reg[4:0] & ~rail_fault_mask_b_reg[4:0])));
      general_output_one <= ~load_pending_reg &
        (&(pg_a_s2_reg | output_one_pg_select_a_reg));
      if (force_on)
        third_ldo_enable <= ctl_s2_reg[0];
      else
        third_ldo_enable <= ctl_s2_reg[2] | ctl_s2_reg[1];
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// bench for the rail mask register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 0, rst = 1, pin = 0, ipg = 0, dis = 1, bw, br, rv, sd, go, en;
  logic [7:0] ad, wd, rdat, fa = 0, fb = 0, pg = 0, ma, mb, sel;
  logic [1:0] x;
  logic [49:0] rows [4] = '{50'h3_0020_0001_00ff, 50'h1_0120_fe01_0001,
    50'h2_ff20_7fff_107f, 50'h1_ffbf_ffff_1f00};
  int error_cnt = 0, num_checks = 0;
  rfpg_host rfpg_host_i (.clk_sys(clk_sys), .reg_wr(bw), .reg_rd(br),
    .reg_addr(ad), .reg_wdata(wd));
  rfpg_regs rfpg_regs_i (.clk_sys(clk_sys), .rst(rst), .otp_override_b(8'h01),
    .otp_fault_mask_a(8'hc0), .otp_fault_mask_b(8'ha7), .otp_pg_select_a(8'h5a),
    .reg_wr(bw), .reg_rd(br), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat),
    .reg_rvalid(rv), .rail_fault_a(fa), .rail_fault_b(fb), .rail_pg_a(pg),
    .third_ldo_ctl_pin_en(pin), .third_ldo_internal_pg_en(ipg),
    .third_ldo_disable_ctl(dis), .shutdown_req(sd), .general_output_one(go),
    .third_ldo_enable(en), .rail_fault_mask_a_out(),
    .rail_fault_mask_b_out(), .output_one_pg_select_a_out());
  task automatic chk(input string s, input logic [7:0] e, g);
  begin
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  end
  endtask
  task automatic rdc(input logic [7:0] a, e);
  begin
    rfpg_host_i.acc(1'b0, a, 8'h00);
    chk("rvalid", 8'h01, {7'h0, rv});
    chk("rdata", e, rdat);
  end
  endtask
  task automatic step(input logic [7:0] a, d, e);
  begin
    rfpg_host_i.acc(1'b1, a, d);
    repeat (4) @(negedge clk_sys);
    chk("ldo", e, {7'h0, en});
  end
  endtask
  task automatic end_sim;
  begin
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial forever #4 clk_sys = ~clk_sys;
  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst = 0;
    repeat (2) @(negedge clk_sys);
    rdc(8'ha2, 8'hc0);
    rdc(8'ha3, 8'h27);
    rdc(8'ha7, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      {x, ma, mb, sel, fa, fb, pg} = rows[i];
      rfpg_host_i.acc(1'b1, 8'ha2, ma);
      rfpg_host_i.acc(1'b1, 8'ha3, mb);
      rfpg_host_i.acc(1'b1, 8'ha4, sel);
      repeat (4) @(negedge clk_sys);
      chk("shutdown", {7'h0, x[1]}, {7'h0, sd});
      chk("pg_out", {7'h0, x[0]}, {7'h0, go});
      rdc(8'ha3, mb & 8'h7f);
      $display("test row %0d done", i);
    end
    pin = 1;
    step(8'ha1, 8'h00, 8'h01);
    pin = 0;
    ipg = 1;
    dis = 0;
    step(8'ha1, 8'h01, 8'h00);
    dis = 1;
    ipg = 0;
    step(8'ha1, 8'h01, 8'h01);
    $display("test ldo done");
    end_sim;
  end
endmodule
bind rfpg_regs rfpg_chk rfpg_chk_i (.*);
`default_nettype wire
